// >>> core/frs_flash_access.sv
// frs_flash_access: segment select, window decode and flash bus cycles
`timescale 1ns/100ps
`default_nettype none

module frs_flash_access
  import frs_pkg::*;
#(
  parameter int ACCESS_CYC   = frs_pkg::FRS_ACCESS_CYC,
  parameter int WE_PULSE_CYC = frs_pkg::FRS_WE_PULSE_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // host io cycles
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic [15:0]          io_addr,
  input  wire logic [7:0]           io_wdata,
  output var  logic [7:0]           io_rdata,
  output var  logic                 io_ack,
  // host byte memory cycles
  input  wire logic                 mem_req,
  input  wire logic                 mem_we,
  input  wire logic [31:0]          mem_addr,
  input  wire logic [7:0]           mem_wdata,
  output var  logic                 mem_busy,
  output var  logic                 mem_ack,
  output var  logic                 mem_hit,
  output var  logic [7:0]           mem_rdata,
  // command tracking status
  output var  frs_pkg::frs_mode_t   flash_mode,
  output var  logic                 cmd_armed,
  output var  logic                 cmd_misuse,
  output var  logic [3:0]           phys_block,
  output var  logic                 upper_half,
  // flash device pins
  output var  logic [18:0]          flash_addr,
  output var  logic                 flash_top_address_line,
  output var  logic                 flash_ce_n,
  output var  logic                 flash_oe_n,
  output var  logic                 flash_we_n,
  output var  logic [7:0]           flash_dq_out,
  output var  logic                 flash_dq_oe_n,
  input  wire logic [7:0]           flash_dq_in
);
  import frs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_SAMPLE,
    ST_WRITE,
    ST_RECOVER
  } frs_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // upper half adds eight to the in-segment block index
  function automatic logic [3:0] frs_block_of(input logic [18:0] ofs,
                                              input logic        upper);
    frs_block_of = upper ? (FRS_UPPER_BLK_BASE | {1'b0, ofs[18:16]})
                         : {1'b0, ofs[18:16]};
  endfunction : frs_block_of

  ////////////////////////////////////////////////////////////////////////////
  // state

  frs_state_t           state;
  logic [FRS_CNT_W-1:0] cnt;
  logic                 half_sel;
  // bookkeeping for the two-cycle setup commands
  logic                 prog_pending;
  logic                 erase_pending;
  logic [18:0]          program_target;
  logic [3:0]           erase_block;
  logic [7:0]           dq_sync1;
  logic [7:0]           dq_sync2;
  logic [7:0]           dq_sync3;
  logic                 cur_we;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        io_sel_hit  = (io_addr == FRS_HALF_SELECT_OFS);
  wire        win_hit     = (mem_addr >= FRS_WIN_BASE) &&
                            (mem_addr <= FRS_WIN_LAST);
  wire [18:0] win_ofs     = mem_addr[FRS_OFS_W-1:0];
  wire [3:0]  req_block   = frs_block_of(win_ofs, half_sel);
  wire        idle        = (state == ST_IDLE);
  wire        start       = mem_req && idle && win_hit;
  wire        miss        = mem_req && idle && !win_hit;
  // while a setup is pending the next write is its operation
  wire        second_wr   = prog_pending || erase_pending;
  wire        wr_first    = start && mem_we && !second_wr;
  wire        wr_second   = start && mem_we && second_wr;
  wire        is_prog_cmd = (mem_wdata == FRS_CMD_PROG_SETUP) ||
                            (mem_wdata == FRS_CMD_PROG_ALT);
  wire        is_erase    = (mem_wdata == FRS_CMD_ERASE_SETUP);
  wire        prog_wrong  = prog_pending && (win_ofs != program_target);
  wire        erase_wrong = erase_pending && (req_block != erase_block);
  wire        cnt_done    = (cnt == '0);
  wire        dq_stable   = (dq_sync2 == dq_sync3);
  wire [FRS_CNT_W-1:0] acc_load = FRS_CNT_W'(ACCESS_CYC - 1);
  wire [FRS_CNT_W-1:0] wep_load = FRS_CNT_W'(WE_PULSE_CYC - 1);

  // of first writes only FF, 90 and 70 move the tracked mode; 50 and B0 leave it
  wire frs_mode_t next_mode =
    (mem_wdata == FRS_CMD_IDENT)       ? FRS_MODE_IDENT  :
    (mem_wdata == FRS_CMD_READ_STATUS) ? FRS_MODE_STATUS :
    (mem_wdata == FRS_CMD_READ_ARRAY)  ? FRS_MODE_ARRAY  :
    flash_mode;

  ////////////////////////////////////////////////////////////////////////////
  // segment select register and io answer

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      half_sel <= FRS_HALF_SELECT_RST[FRS_HALF_SELECT_BIT];
      io_ack   <= 1'b0;
      io_rdata <= FRS_IO_READ_DATA;
    end else begin
      if (io_wr && io_sel_hit) begin
        half_sel <= io_wdata[FRS_HALF_SELECT_BIT];
      end
      io_ack   <= (io_wr || io_rd) && io_sel_hit;
      io_rdata <= FRS_IO_READ_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  // a byte counts once stages two and three agree

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dq_sync1 <= 8'h00;
      dq_sync2 <= 8'h00;
      dq_sync3 <= 8'h00;
    end else begin
      dq_sync1 <= flash_dq_in;
      dq_sync2 <= dq_sync1;
      dq_sync3 <= dq_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command tracking

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flash_mode     <= FRS_MODE_ARRAY;
      prog_pending   <= 1'b0;
      erase_pending  <= 1'b0;
      program_target <= '0;
      erase_block    <= 4'h0;
      cmd_misuse     <= 1'b0;
      cmd_armed      <= 1'b0;
    end else begin
      cmd_misuse <= 1'b0;
      // a misplaced second write still reaches the chip; it is only flagged
      if (wr_first) begin
        // 50 and B0 need no particular address
        flash_mode <= next_mode;
        if (is_prog_cmd) begin
          prog_pending   <= 1'b1;
          program_target <= win_ofs;
        end
        if (is_erase) begin
          erase_pending <= 1'b1;
          erase_block   <= req_block;
        end
        cmd_armed <= is_prog_cmd || is_erase;
      end else if (wr_second) begin
        // the second cycle performs the operation; device reports status
        prog_pending  <= 1'b0;
        erase_pending <= 1'b0;
        cmd_armed     <= 1'b0;
        cmd_misuse    <= prog_wrong || erase_wrong;
        flash_mode    <= FRS_MODE_STATUS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash bus cycle sequencer

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state                  <= ST_IDLE;
      cnt                    <= '0;
      cur_we                 <= 1'b0;
      mem_busy               <= 1'b0;
      mem_ack                <= 1'b0;
      mem_hit                <= 1'b0;
      mem_rdata              <= 8'h00;
      phys_block             <= 4'h0;
      upper_half             <= 1'b0;
      flash_addr             <= '0;
      flash_top_address_line <= 1'b0;
      flash_ce_n             <= 1'b1;
      flash_oe_n             <= 1'b1;
      flash_we_n             <= 1'b1;
      flash_dq_out           <= 8'h00;
      flash_dq_oe_n          <= 1'b1;
    end else begin
      mem_ack                <= 1'b0;
      upper_half             <= half_sel;
      flash_top_address_line <= half_sel;
      unique case (state)
        ST_IDLE: begin
          // unmapped addresses answer at once with the idle-bus byte
          if (miss) begin
            mem_ack   <= 1'b1;
            mem_hit   <= 1'b0;
            mem_rdata <= FRS_UNMAPPED_DATA;
          end else if (start) begin
            mem_busy   <= 1'b1;
            cur_we     <= mem_we;
            phys_block <= req_block;
            flash_addr <= win_ofs;
            flash_ce_n <= 1'b0;
            if (mem_we) begin
              flash_we_n    <= 1'b0;
              flash_dq_out  <= mem_wdata;
              flash_dq_oe_n <= 1'b0;
              cnt           <= wep_load;
              state         <= ST_WRITE;
            end else begin
              // plain read: no command cycle needed
              flash_oe_n <= 1'b0;
              cnt        <= acc_load;
              state      <= ST_READ;
            end
          end
        end
        ST_READ: begin
          // give the chip its access time before sampling
          if (cnt_done) begin
            state <= ST_SAMPLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_SAMPLE: begin
          // wait until the synchronised data has settled
          if (dq_stable) begin
            mem_rdata  <= dq_sync3;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            state      <= ST_RECOVER;
          end
        end
        ST_WRITE: begin
          // strobe held low for the write pulse, data already driven
          if (cnt_done) begin
            flash_we_n <= 1'b1;
            state      <= ST_RECOVER;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_RECOVER: begin
          // data held one cycle past the write strobe rising
          flash_ce_n    <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          mem_busy      <= 1'b0;
          mem_ack       <= 1'b1;
          mem_hit       <= 1'b1;
          if (cur_we) begin
            mem_rdata <= 8'h00;
          end
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : frs_flash_access

`default_nettype wire

// >>> core/frs_pkg.sv
// frs_pkg: constants for the flash segment and command access block
package frs_pkg;

  // host io space: segment select location
  localparam logic [15:0] FRS_HALF_SELECT_OFS  = 16'h0800;
  localparam logic [7:0]  FRS_HALF_SELECT_RST  = 8'h00;
  localparam int          FRS_HALF_SELECT_BIT  = 0;

  // host memory space: flash window
  localparam logic [31:0] FRS_WIN_BASE         = 32'hFFF8_0000;
  localparam logic [31:0] FRS_WIN_LAST         = 32'hFFFF_FFFF;
  localparam int          FRS_OFS_W            = 19;
  localparam int          FRS_BLK_LSB          = 16;
  localparam logic [3:0]  FRS_UPPER_BLK_BASE   = 4'h8;

  // flash command bytes
  localparam logic [7:0]  FRS_CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0]  FRS_CMD_IDENT        = 8'h90;
  localparam logic [7:0]  FRS_CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0]  FRS_CMD_CLR_STATUS   = 8'h50;
  localparam logic [7:0]  FRS_CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0]  FRS_CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0]  FRS_CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0]  FRS_CMD_PROG_ALT     = 8'h10;

  // answer for an unmapped memory read and for io reads
  localparam logic [7:0]  FRS_UNMAPPED_DATA    = 8'hFF;
  localparam logic [7:0]  FRS_IO_READ_DATA     = 8'h00;

  // flash timing, clk_sys at 125 MHz
  localparam int          FRS_CLK_PERIOD_PS    = 8000;
  localparam int          FRS_T_ACCESS_NS      = 120;
  localparam int          FRS_T_WE_PULSE_NS    = 60;
  localparam int          FRS_ACCESS_CYC       =
    (FRS_T_ACCESS_NS * 1000 + FRS_CLK_PERIOD_PS - 1) / FRS_CLK_PERIOD_PS;
  localparam int          FRS_WE_PULSE_CYC     =
    (FRS_T_WE_PULSE_NS * 1000 + FRS_CLK_PERIOD_PS - 1) / FRS_CLK_PERIOD_PS;
  localparam int          FRS_CNT_W            = 8;

  // read mode the flash is currently left in
  typedef enum logic [1:0] {
    FRS_MODE_ARRAY,
    FRS_MODE_IDENT,
    FRS_MODE_STATUS
  } frs_mode_t;

endpackage : frs_pkg

// >>> sim/frs_flash_access_properties.sv
// frs_flash_access_properties: port checker for the flash access block
`timescale 1ns/100ps
`default_nettype none
module frs_flash_access_properties
  import frs_pkg::*;
(
  // watched ports
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_ack,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_busy,
  input wire logic        mem_ack,
  input wire logic        mem_hit,
  input wire logic [7:0]  mem_rdata,
  input wire logic        cmd_armed,
  input wire logic        cmd_misuse,
  input wire logic [3:0]  phys_block,
  input wire logic        upper_half,
  input wire logic        flash_top_address_line,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_dq_oe_n
);
  logic        exp_hit;
  logic [2:0]  exp_blk;
  wire take = mem_req && !mem_busy;
  wire sel  = (io_wr || io_rd) && io_addr == FRS_HALF_SELECT_OFS;
  always_ff @(posedge clk_sys) begin
    if (take) begin
      exp_hit <= mem_addr >= FRS_WIN_BASE;
      exp_blk <= mem_addr[18:16];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_io_ack_pulse: assert property (sel |=> io_ack)
    else $error("io ack missing");
  a_io_ack_cause: assert property (io_ack |-> $past(sel))
    else $error("io ack without select access");
  a_io_read_zero: assert property (io_rdata == FRS_IO_READ_DATA)
    else $error("io read data not zero");
  a_sel_store: assert property (sel && io_wr ##1 !srst |=>
    upper_half == $past(io_wdata[FRS_HALF_SELECT_BIT], 2))
    else $error("segment select not stored");
  a_sel_reset: assert property ($fell(srst) |-> !upper_half)
    else $error("segment select not lower after reset");
  a_top_line: assert property (flash_top_address_line == upper_half)
    else $error("top address line differs from select");
  a_hit_range: assert property (mem_ack |-> mem_hit == exp_hit)
    else $error("hit flag wrong for address");
  a_block_number: assert property (mem_ack && mem_hit |->
    phys_block == {upper_half, exp_blk})
    else $error("physical block wrong");
  a_miss_answer: assert property (take && mem_addr < FRS_WIN_BASE |=>
    mem_ack && mem_rdata == FRS_UNMAPPED_DATA)
    else $error("miss not answered at once");
  a_read_direct: assert property (take && !mem_we &&
    mem_addr >= FRS_WIN_BASE |=> !flash_ce_n && !flash_oe_n && flash_we_n)
    else $error("read did not start a flash read");
  a_write_drive: assert property (!flash_we_n |->
    !flash_ce_n && !flash_dq_oe_n && flash_oe_n)
    else $error("write strobe without data drive");
  a_misuse_armed: assert property (cmd_misuse |-> $past(cmd_armed))
    else $error("misuse without armed setup");
  a_busy_span: assert property (mem_ack |->
    !mem_busy && mem_hit == $past(mem_busy))
    else $error("busy level wrong around answer");
endmodule : frs_flash_access_properties
bind frs_flash_access frs_flash_access_properties u_props (.clk_sys, .srst,
  .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_ack, .mem_req, .mem_we,
  .mem_addr, .mem_busy, .mem_ack, .mem_hit, .mem_rdata, .cmd_armed,
  .cmd_misuse, .phys_block, .upper_half, .flash_top_address_line,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe_n);
`default_nettype wire

// >>> sim/frs_flash_model.sv
// frs_flash_model: behavioural byte-wide flash chip for the bench
`timescale 1ns/100ps
`default_nettype none
module frs_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // arbitrary value
) (
  // clock
  input  wire logic        clk_sys,
  // flash pins
  input  wire logic [18:0] flash_addr,
  input  wire logic        flash_top_address_line,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        flash_dq_oe_n,
  output var  logic [7:0]  flash_dq_in
);
  logic [7:0]  mem [int];
  logic [15:0] erased = 16'h0000;
  logic [1:0]  mode = 2'd0;
  logic        pend = 1'b0;
  logic        ers = 1'b0;
  logic [7:0]  last = 8'h00;
  logic [7:0]  rd;
  wire  [19:0] a = {flash_top_address_line, flash_addr};
  wire         drive = !flash_ce_n && !flash_oe_n;
  function automatic logic [7:0] arr(input logic [19:0] x);
    if (mem.exists(x)) return mem[x];
    if (erased[x[19:16]]) return 8'hFF;
    return x[7:0] ^ x[15:8] ^ {4'h0, x[19:16]};
  endfunction : arr
  always @* begin
    case (mode)
      2'd1: rd = ID_CODE;
      2'd2: rd = 8'h80;
      default: rd = arr(a);
    endcase
  end
  // released bus shows the inverse of the last byte
  assign flash_dq_in = drive ? rd : ~last;
  always @(posedge clk_sys) if (drive) last <= rd;
  always @(posedge flash_we_n) begin
    if (flash_ce_n === 1'b0 && flash_dq_oe_n === 1'b0) begin
      if (pend) begin
        if (ers) erased[a[19:16]] = 1'b1;
        else mem[a] = arr(a) & flash_dq_out;
        pend = 1'b0;
        mode = 2'd2;
      end else begin
        case (flash_dq_out)
          8'hFF: mode = 2'd0;
          8'h90: mode = 2'd1;
          8'h70: mode = 2'd2;
          8'h20, 8'h40, 8'h10: begin
            pend = 1'b1;
            ers = flash_dq_out == 8'h20;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : frs_flash_model
`default_nettype wire

// >>> sim/tb.sv
// tb: directed bench for the flash segment and command access block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import frs_pkg::*;
  localparam logic [7:0] ID = 8'h5A; // arbitrary value
  logic clk_sys = 0, srst = 1, io_wr = 0, io_rd = 0, mem_req = 0, mem_we = 0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  io_wdata = 8'h00, mem_wdata = 8'h00, io_rdata, mem_rdata, rd;
  logic [7:0]  flash_dq_out, flash_dq_in;
  logic [31:0] mem_addr = 32'h0000_0000;
  logic io_ack, mem_busy, mem_ack, mem_hit, cmd_armed, cmd_misuse, hit;
  logic upper_half, flash_top_address_line, flash_ce_n, flash_oe_n;
  logic flash_we_n, flash_dq_oe_n, seen_misuse = 0;
  logic [3:0]  phys_block;
  logic [18:0] flash_addr;
  frs_mode_t   flash_mode;
  int mismatches = 0, n_tests = 0;
  logic [7:0] cmds [5] = '{8'h90, 8'h70, 8'h50, 8'hB0, 8'hFF};
  logic [7:0] exps [5] = '{ID, 8'h80, 8'h80, 8'h80, 8'h10};
  frs_mode_t modes [5] = '{FRS_MODE_IDENT, FRS_MODE_STATUS, FRS_MODE_STATUS,
                           FRS_MODE_STATUS, FRS_MODE_ARRAY};
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (cmd_misuse === 1'b1) seen_misuse <= 1'b1;
  frs_flash_access #(.ACCESS_CYC(2), .WE_PULSE_CYC(2)) u_frs_flash_access (
    .clk_sys, .srst, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_ack,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_busy, .mem_ack, .mem_hit,
    .mem_rdata, .flash_mode, .cmd_armed, .cmd_misuse, .phys_block,
    .upper_half, .flash_addr, .flash_top_address_line, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in);
  frs_flash_model #(.ID_CODE(ID)) u_frs_flash_model (.clk_sys, .flash_addr,
    .flash_top_address_line, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_dq_out, .flash_dq_oe_n, .flash_dq_in);
  function automatic logic [7:0] pat(input logic [19:0] x);
    return x[7:0] ^ x[15:8] ^ {4'h0, x[19:16]};
  endfunction : pat
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic io_op(input logic we, input logic [15:0] ad,
                       input logic [7:0] d, input logic ack);
    @(posedge clk_sys) #1;
    {io_wr, io_rd, io_addr, io_wdata} = {we, !we, ad, d};
    @(posedge clk_sys) #1;
    {io_wr, io_rd} = 2'b00;
    check(io_ack, ack);
    check(io_rdata, 8'h00);
    @(posedge clk_sys) #1;
  endtask : io_op
  task automatic mem_op(input logic we, input logic [31:0] ad,
                        input logic [7:0] d);
    @(posedge clk_sys) #1;
    {mem_req, mem_we, mem_addr, mem_wdata} = {1'b1, we, ad, d};
    @(posedge clk_sys) #1;
    mem_req = 0;
    for (int i = 0; i < 100 && mem_ack !== 1'b1; i++) @(posedge clk_sys) #1;
    check(mem_ack, 1'b1);
    {hit, rd} = {mem_hit, mem_rdata};
  endtask : mem_op
  task automatic mrd(input logic [31:0] ad, input logic [7:0] e,
                     input logic h);
    mem_op(0, ad, 8'h00);
    check(hit, h);
    check(rd, e);
  endtask : mrd
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 srst = 0;
    check(upper_half, 1'b0);
    check(flash_mode, FRS_MODE_ARRAY);
    io_op(0, 16'h0800, 8'h00, 1);
    io_op(1, 16'h0801, 8'h01, 0);
    check(upper_half, 1'b0);
    io_op(1, 16'h0800, 8'hFF, 1);
    check(flash_top_address_line, 1'b1);
    mrd(32'hFFFB_1234, pat(20'hB_1234), 1);
    check(phys_block, 4'hB);
    io_op(1, 16'h0800, 8'hFE, 1);
    check(flash_top_address_line, 1'b0);
    mrd(32'hFFFB_1234, pat(20'h3_1234), 1);
    check(phys_block, 4'h3);
    mrd(32'hFFF7_FFFF, FRS_UNMAPPED_DATA, 0);
    mrd(32'hFFFF_FFFF, pat(20'h7_FFFF), 1);
    $display("test select and window done");
    for (int i = 0; i < 5; i++) begin
      mem_op(1, 32'hFFF8_0000 + 32'h0001_1111 * i, cmds[i]);
      mrd(32'hFFF8_0010, exps[i], 1);
      check(flash_mode, modes[i]);
    end
    $display("test command codes done");
    mem_op(1, 32'hFFFA_0000, FRS_CMD_ERASE_SETUP);
    check(cmd_armed, 1'b1);
    mem_op(1, 32'hFFFA_8000, 8'hD0);
    check(cmd_armed, 1'b0);
    check(flash_mode, FRS_MODE_STATUS);
    mem_op(1, 32'hFFFA_0000, FRS_CMD_READ_ARRAY);
    mrd(32'hFFFA_5555, 8'hFF, 1);
    mrd(32'hFFFB_0000, pat(20'h3_0000), 1);
    mem_op(1, 32'hFFFA_0100, FRS_CMD_PROG_SETUP);
    mem_op(1, 32'hFFFA_0100, 8'h3C);
    check(seen_misuse, 1'b0);
    mem_op(1, 32'hFFFA_0100, FRS_CMD_PROG_ALT);
    mem_op(1, 32'hFFFA_0200, 8'hC3);
    check(seen_misuse, 1'b1);
    mem_op(1, 32'hFFFA_0000, FRS_CMD_READ_ARRAY);
    mrd(32'hFFFA_0100, 8'h3C, 1);
    mrd(32'hFFFA_0200, 8'hC3, 1);
    $display("test erase and program done");
    io_op(1, 16'h0800, 8'h01, 1);
    check(upper_half, 1'b1);
    @(posedge clk_sys) #1 srst = 1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 0;
    @(posedge clk_sys) #1;
    check(upper_half, 1'b0);
    check(flash_top_address_line, 1'b0);
    $display("test reset in run done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
